// ### hdl/jdr_defs.svh
/*
  Constants of the receive deframer and LMFC sync block: register offsets,
  bit positions, mode codes, reset values and cycle counts.
  Assumes inclusion by the package, the block and the checker only.
*/
`ifndef JDR_DEFS_SVH
`define JDR_DEFS_SVH

`define JDR_LANES 8
`define JDR_LINKS 2
`define JDR_LANES_PER_LINK 4
`define JDR_OCTETS 4
`define JDR_SYM_W 10
`define JDR_OCT_W 8
`define JDR_ADDR_W 12
`define JDR_DATA_W 8

`define JDR_A_ERR_WINDOW 12'h034
`define JDR_A_SNAP_ERR 12'h038
`define JDR_A_SNAP_FLAGS 12'h039
`define JDR_A_SYNC_CTL 12'h03A
`define JDR_A_SYNC_STATUS 12'h03B
`define JDR_A_LIVE_ERR 12'h03C
`define JDR_A_WIN_FLAGS 12'h03D
`define JDR_A_LINK_MODE 12'h300
`define JDR_A_LANE_INV 12'h334
`define JDR_A_DESCRAMBLE 12'h453

`define JDR_B_TWO_LINK 3
`define JDR_B_LINK_SEL 2
`define JDR_B_DESCR_EN 7
`define JDR_B_SYNC_EN 7
`define JDR_B_SYNC_ARM 6
`define JDR_B_CLR_STICKY 5
`define JDR_B_BUSY 7
`define JDR_B_LOCK 3
`define JDR_B_ROTATED 2
`define JDR_B_WIN_LIMIT 1
`define JDR_B_TRIPPED 0
`define JDR_B_FLAG_LOW 7
`define JDR_B_FLAG_HIGH 6

`define JDR_MODE_ONE_SHOT 4'h1
`define JDR_MODE_CONTINUOUS 4'h2
`define JDR_MODE_MONITOR 4'h9
`define JDR_CTL_STORE_MASK 8'hDF
`define JDR_WIN_FIELD_MASK 8'h07
`define JDR_SNAP_ERR_MASK 8'h0F
`define JDR_RST_BYTE 8'h00

`define JDR_LMFC_PERIOD 8'h20
`define JDR_LMFC_HALF 8'h10
`define JDR_LMFC_LAST 8'h1F
`define JDR_LMFC_ZERO 8'h00
`define JDR_LMFC_AFTER_ALIGN 8'h01
`define JDR_ROT_CYCLES 4'h4
`define JDR_ROT_LAST 4'h1

`define JDR_SCR_LEN 15
`define JDR_SCR_TAP_A 13
`define JDR_SCR_TAP_B 14
`define JDR_K28_RD_POS 6'b110000

`endif

// ### hdl/jdr_pkg.sv
/*
  Types of the receive deframer and LMFC sync block.
  Assumes jdr_defs.svh on the include path.
*/
`include "jdr_defs.svh"

package jdr_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`JDR_ADDR_W-1:0] addr;
    logic [`JDR_DATA_W-1:0] wdata;
  } jdr_reg_req_type;

  typedef logic [`JDR_LANES-1:0][`JDR_OCTETS-1:0][`JDR_SYM_W-1:0] jdr_sym_bus_type;

  typedef struct packed {
    logic valid;
    logic [`JDR_LANES_PER_LINK-1:0][`JDR_OCTETS-1:0][`JDR_OCT_W-1:0] data;
    logic [`JDR_LANES_PER_LINK*`JDR_OCTETS-1:0] is_ctrl;
    logic [`JDR_LANES_PER_LINK*`JDR_OCTETS-1:0] code_err;
  } jdr_frame_type;

  typedef enum logic [3:0] {
    JDR_ST_IDLE = 4'b0001,
    JDR_ST_WAIT = 4'b0010,
    JDR_ST_ROTATE = 4'b0100,
    JDR_ST_MONITOR = 4'b1000
  } jdr_sync_state_type;

endpackage

// ### hdl/jdr_rx_link.sv
/*
  Receive link layer: lane inversion, 8b/10b decode, optional descramble for
  two quad-octet deframers, and LMFC phase sync to SYSREF or an internal edge,
  with a byte-wide register port.
  Assumes lane symbols arrive on core_clk (the processing clock) from the
  lane switch, and SYSREF arrives asynchronously on a pin.
*/
`timescale 1ns/100ps
`include "jdr_defs.svh"

// How it works
// [RQ1] Bit x of lane inversion register inverts logical lane x, eight lanes independently.
// [RQ2] Each deframer takes four octets per lane on every processing clock.
// [RQ3] Two-link bit on: both deframers run; off: deframer 1 stays idle.
// [RQ4] Link-select bit steers per-link register accesses to that link's settings.
// [RQ5] Deframers decode 8b/10b, optionally descramble, then pass frames onward.
// [RQ6] Descrambler is self-synchronising with polynomial 1 + x^14 + x^15.
// [RQ7] Descrambling applies only while the descramble enable bit is one.
// [RQ8] Each converter pair, A and B, has its own LMFC counter.
// [RQ9] Alignment edge is SYSREF in subclass 1, internal edge in subclass 0.
// [RQ10] SYSREF is active high, sampled on the rising clock edge.
// [RQ11] SYSREF may be a pulse, a step or any periodic waveform.
// [RQ12] Every mode compares LMFC phase to the edge and rotates when misaligned; monitor mode rotates only on its first armed edge.
// [RQ13] One-shot checks only the first edge after arming, rotating beyond window.
// [RQ14] Continuous checks every edge without arming, for periodic subclass 1 SYSREF.
// [RQ15] Edges arriving during a rotation are ignored until rotation ends.
// [RQ16] Continuous with a window checks each edge, realigns only beyond window.
// [RQ17] Software should prefer subclass 0 one-shot when window exceeds three.
// [RQ18] Arm bit self-clears on an edge; in continuous it only indicates edges.
// [RQ19] Monitor mode aligns on the first armed edge, then only reports.
// [RQ20] Live phase error reads zero after alignment, then reports later drift.
// [RQ21] Error beyond window sets the low-side or high-side flag bit.
// [RQ22] Alignment copies last error and its flags into snapshot registers.
// [RQ23] Modes encode 0x01, 0x02, 0x09; window codes 0x00 to 0x07.
// [RQ24] Rotation and trip flags are sticky until the clear-sticky bit is written.
module jdr_rx_link (
  input logic core_clk,                       // processing clock
  input logic rst,                            // synchronous reset, active high
  input jdr_pkg::jdr_reg_req_type reg_req,    // register write/read request
  output logic [`JDR_DATA_W-1:0] reg_rdata,   // read data, one cycle after rd
  input jdr_pkg::jdr_sym_bus_type lane_sym,   // four 10-bit symbols per lane
  input logic [`JDR_LINKS-1:0] lane_valid,    // symbols valid, per link
  input logic subclass1,                      // 1: subclass 1, 0: subclass 0
  input logic sysref,                         // SYSREF pin, asynchronous
  input logic [`JDR_LINKS-1:0] dual_sync_sel, // which pairs take part in sync
  output jdr_pkg::jdr_frame_type [`JDR_LINKS-1:0] frame_out, // frames per link
  output logic [`JDR_LINKS-1:0] lmfc_edge     // LMFC boundary pulse, per pair
);
  import jdr_pkg::*;

  // decode one symbol {a..e,i,f..j}: returns {code_err, is_ctrl, octet}
  function automatic logic [9:0] decode_symbol(input logic [9:0] sym);
    logic [5:0] six;
    logic [3:0] four;
    logic [4:0] low;
    logic [2:0] high;
    logic bad;
    logic ctrl;
    six = sym[9:4];
    four = sym[3:0];
    low = '0;
    high = '0;
    bad = 1'b0;
    ctrl = 1'b0;
    case (six)
      6'b100111, 6'b011000: low = 5'h00;
      6'b011101, 6'b100010: low = 5'h01;
      6'b101101, 6'b010010: low = 5'h02;
      6'b110001: low = 5'h03;
      6'b110101, 6'b001010: low = 5'h04;
      6'b101001: low = 5'h05;
      6'b011001: low = 5'h06;
      6'b111000, 6'b000111: low = 5'h07;
      6'b111001, 6'b000110: low = 5'h08;
      6'b100101: low = 5'h09;
      6'b010101: low = 5'h0A;
      6'b110100: low = 5'h0B;
      6'b001101: low = 5'h0C;
      6'b101100: low = 5'h0D;
      6'b011100: low = 5'h0E;
      6'b010111, 6'b101000: low = 5'h0F;
      6'b011011, 6'b100100: low = 5'h10;
      6'b100011: low = 5'h11;
      6'b010011: low = 5'h12;
      6'b110010: low = 5'h13;
      6'b001011: low = 5'h14;
      6'b101010: low = 5'h15;
      6'b011010: low = 5'h16;
      6'b111010, 6'b000101: low = 5'h17;
      6'b110011, 6'b001100: low = 5'h18;
      6'b100110: low = 5'h19;
      6'b010110: low = 5'h1A;
      6'b110110, 6'b001001: low = 5'h1B;
      6'b001110: low = 5'h1C;
      6'b101110, 6'b010001: low = 5'h1D;
      6'b011110, 6'b100001: low = 5'h1E;
      6'b101011, 6'b010100: low = 5'h1F;
      6'b001111, 6'b110000: begin
        low = 5'h1C;
        ctrl = 1'b1;
      end
      default: bad = 1'b1;
    endcase
    // positive-disparity K28 carries the complemented 4b code
    if (six == `JDR_K28_RD_POS) begin
      four = ~four;
    end
    case (four)
      4'b1011, 4'b0100: high = 3'h0;
      4'b1001: high = 3'h1;
      4'b0101: high = 3'h2;
      4'b1100, 4'b0011: high = 3'h3;
      4'b1101, 4'b0010: high = 3'h4;
      4'b1010: high = 3'h5;
      4'b0110: high = 3'h6;
      4'b1110, 4'b0001, 4'b0111, 4'b1000: high = 3'h7;
      default: bad = 1'b1;
    endcase
    return {bad, ctrl, high, low};
  endfunction

  // self-synchronising descramble of four octets, octet 0 first, msb first
  function automatic logic [`JDR_SCR_LEN+31:0] descramble_word(
    input logic [31:0] word,
    input logic [`JDR_SCR_LEN-1:0] hist
  );
    logic [`JDR_SCR_LEN-1:0] s;
    logic [31:0] o;
    s = hist;
    o = '0;
    for (int oc = 0; oc < `JDR_OCTETS; oc++) begin
      for (int b = `JDR_OCT_W - 1; b >= 0; b--) begin
        o[oc*`JDR_OCT_W+b] = word[oc*`JDR_OCT_W+b] ^ s[`JDR_SCR_TAP_A] ^ s[`JDR_SCR_TAP_B]; // see [RQ6]
        s = {s[`JDR_SCR_LEN-2:0], word[oc*`JDR_OCT_W+b]};
      end
    end
    return {s, o};
  endfunction

  // register and sync state
  logic [7:0] err_window, next_err_window;
  logic [7:0] snap_err, next_snap_err;
  logic [7:0] snap_flags, next_snap_flags;
  logic [7:0] sync_ctl, next_sync_ctl;
  logic [7:0] live_err, next_live_err;
  logic [7:0] win_flags, next_win_flags;
  logic [7:0] link_mode, next_link_mode;
  logic [7:0] lane_inv, next_lane_inv;
  logic [`JDR_LINKS-1:0][7:0] descr_ctl, next_descr_ctl;
  logic rotated, next_rotated;
  logic tripped, next_tripped;
  logic locked, next_locked;
  logic win_limit, next_win_limit;
  jdr_sync_state_type state, next_state;
  jdr_sync_state_type after_rot, next_after_rot;
  logic [3:0] rot_cnt, next_rot_cnt;
  logic [`JDR_DATA_W-1:0] next_rdata;
  logic [7:0] ref_cnt, next_ref_cnt;
  logic [`JDR_LINKS-1:0][7:0] lmfc_cnt, next_lmfc_cnt;
  logic [`JDR_LINKS-1:0] next_lmfc_edge;
  logic sysref_meta, sysref_sync, sysref_prev;
  logic sysref_rise;

  // derived link controls
  logic [`JDR_LINKS-1:0] link_on;
  logic [`JDR_LINKS-1:0] descr_on;
  logic bank;

  assign bank = link_mode[`JDR_B_TWO_LINK] & link_mode[`JDR_B_LINK_SEL]; // see [RQ4]
  assign link_on = {link_mode[`JDR_B_TWO_LINK], 1'b1}; // see [RQ3]
  assign descr_on = {descr_ctl[1][`JDR_B_DESCR_EN], descr_ctl[0][`JDR_B_DESCR_EN]};

  // SYSREF: two flops, then rising-edge detect past the synchroniser
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
      sysref_prev <= 1'b0;
    end else begin
      sysref_meta <= sysref;
      sysref_sync <= sysref_meta;
      sysref_prev <= sysref_sync;
    end
  end
  assign sysref_rise = sysref_sync & ~sysref_prev; // see [RQ10] [RQ11]

  always_comb begin
    logic edge_in;
    logic [7:0] cnt;
    logic [7:0] mag;
    logic [7:0] serr;
    logic [7:0] flags;
    logic exceed;
    logic check;
    logic align;
    logic busy;
    logic [7:0] status;
    edge_in = subclass1 ? sysref_rise : (ref_cnt == `JDR_LMFC_ZERO); // see [RQ9]
    busy = (state == JDR_ST_ROTATE) ||
           (state == JDR_ST_WAIT && sync_ctl[3:0] != `JDR_MODE_CONTINUOUS);
    status = '0;
    cnt = dual_sync_sel[0] ? lmfc_cnt[0] : lmfc_cnt[1];
    mag = (cnt < `JDR_LMFC_HALF) ? cnt : 8'(`JDR_LMFC_PERIOD - cnt);
    serr = (cnt < `JDR_LMFC_HALF) ? cnt : 8'(cnt - `JDR_LMFC_PERIOD);
    exceed = mag > (err_window & `JDR_WIN_FIELD_MASK); // see [RQ16] [RQ23]
    flags = '0;
    if (exceed) begin
      flags[`JDR_B_FLAG_HIGH] = (cnt < `JDR_LMFC_HALF); // see [RQ21]
      flags[`JDR_B_FLAG_LOW] = ~(cnt < `JDR_LMFC_HALF);
    end
    check = 1'b0;
    align = 1'b0;
    next_err_window = err_window;
    next_snap_err = snap_err;
    next_snap_flags = snap_flags;
    next_sync_ctl = sync_ctl;
    next_live_err = live_err;
    next_win_flags = win_flags;
    next_link_mode = link_mode;
    next_lane_inv = lane_inv;
    next_descr_ctl = descr_ctl;
    next_rotated = rotated;
    next_tripped = tripped;
    next_locked = locked;
    next_win_limit = win_limit;
    next_state = state;
    next_after_rot = after_rot;
    next_rot_cnt = rot_cnt;

    // sync machine
    if (!sync_ctl[`JDR_B_SYNC_EN]) begin
      next_state = JDR_ST_IDLE;
    end else begin
      unique case (state)
        JDR_ST_IDLE: begin
          if (sync_ctl[3:0] == `JDR_MODE_CONTINUOUS) begin
            next_state = JDR_ST_WAIT; // see [RQ14]
          end else if (sync_ctl[`JDR_B_SYNC_ARM] && (sync_ctl[3:0] == `JDR_MODE_ONE_SHOT ||
                       sync_ctl[3:0] == `JDR_MODE_MONITOR)) begin
            next_state = JDR_ST_WAIT; // see [RQ13] [RQ19]
          end
        end
        JDR_ST_WAIT: begin
          if (edge_in) begin
            check = 1'b1; // see [RQ12]
            align = exceed;
            if (sync_ctl[3:0] == `JDR_MODE_CONTINUOUS) begin
              next_after_rot = JDR_ST_WAIT;
            end else if (sync_ctl[3:0] == `JDR_MODE_MONITOR) begin
              next_after_rot = JDR_ST_MONITOR;
            end else begin
              next_after_rot = JDR_ST_IDLE; // see [RQ13]
            end
            next_state = exceed ? JDR_ST_ROTATE : next_after_rot;
            next_rot_cnt = `JDR_ROT_CYCLES;
          end
        end
        JDR_ST_ROTATE: begin
          next_rot_cnt = 4'(rot_cnt - 4'h1);
          if (rot_cnt == `JDR_ROT_LAST) begin
            next_state = after_rot; // see [RQ15]
          end
        end
        JDR_ST_MONITOR: begin
          check = edge_in; // see [RQ19]
        end
        default: next_state = JDR_ST_IDLE;
      endcase
    end

    if (edge_in && sync_ctl[`JDR_B_SYNC_EN]) begin
      next_sync_ctl[`JDR_B_SYNC_ARM] = 1'b0; // see [RQ18]
    end

    // software writes; an arm written with an edge survives
    if (reg_req.wr) begin
      case (reg_req.addr)
        `JDR_A_ERR_WINDOW: next_err_window = reg_req.wdata;
        `JDR_A_SYNC_CTL: begin
          next_sync_ctl = reg_req.wdata & `JDR_CTL_STORE_MASK;
          if (reg_req.wdata[`JDR_B_CLR_STICKY]) begin
            next_rotated = 1'b0; // see [RQ24]
            next_tripped = 1'b0;
          end
        end
        `JDR_A_LINK_MODE: next_link_mode = reg_req.wdata;
        `JDR_A_LANE_INV: next_lane_inv = reg_req.wdata;
        `JDR_A_DESCRAMBLE: next_descr_ctl[bank] = reg_req.wdata; // see [RQ4] [RQ7]
        default: ;
      endcase
    end

    // results of a phase check; hardware sets win over a sticky clear
    if (check) begin
      next_tripped = 1'b1; // see [RQ24]
      next_live_err = serr; // see [RQ20]
      next_win_flags = flags; // see [RQ21]
      next_locked = ~exceed;
      next_win_limit = exceed;
    end
    if (align) begin
      next_rotated = 1'b1; // see [RQ24]
      next_snap_err = serr & `JDR_SNAP_ERR_MASK; // see [RQ22]
      next_snap_flags = flags;
      next_live_err = `JDR_RST_BYTE; // see [RQ20]
      next_win_flags = `JDR_RST_BYTE;
      next_locked = 1'b1;
    end

    // LMFC counters, one per pair
    next_ref_cnt = (ref_cnt == `JDR_LMFC_LAST) ? `JDR_LMFC_ZERO : 8'(ref_cnt + 8'h01);
    for (int d = 0; d < `JDR_LINKS; d++) begin
      if (align && dual_sync_sel[d]) begin
        next_lmfc_cnt[d] = `JDR_LMFC_AFTER_ALIGN; // see [RQ8] [RQ12]
      end else if (lmfc_cnt[d] == `JDR_LMFC_LAST) begin
        next_lmfc_cnt[d] = `JDR_LMFC_ZERO;
      end else begin
        next_lmfc_cnt[d] = 8'(lmfc_cnt[d] + 8'h01);
      end
      next_lmfc_edge[d] = (next_lmfc_cnt[d] == `JDR_LMFC_ZERO);
    end

    // read path
    status[`JDR_B_BUSY] = busy;
    status[`JDR_B_LOCK] = locked;
    status[`JDR_B_ROTATED] = rotated;
    status[`JDR_B_WIN_LIMIT] = win_limit;
    status[`JDR_B_TRIPPED] = tripped;
    next_rdata = reg_rdata;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `JDR_A_ERR_WINDOW: next_rdata = err_window;
        `JDR_A_SNAP_ERR: next_rdata = snap_err;
        `JDR_A_SNAP_FLAGS: next_rdata = snap_flags;
        `JDR_A_SYNC_CTL: next_rdata = sync_ctl;
        `JDR_A_SYNC_STATUS: next_rdata = status;
        `JDR_A_LIVE_ERR: next_rdata = live_err;
        `JDR_A_WIN_FLAGS: next_rdata = win_flags;
        `JDR_A_LINK_MODE: next_rdata = link_mode;
        `JDR_A_LANE_INV: next_rdata = lane_inv;
        `JDR_A_DESCRAMBLE: next_rdata = descr_ctl[bank];
        default: next_rdata = `JDR_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_window <= `JDR_RST_BYTE;
      snap_err <= `JDR_RST_BYTE;
      snap_flags <= `JDR_RST_BYTE;
      sync_ctl <= `JDR_RST_BYTE;
      live_err <= `JDR_RST_BYTE;
      win_flags <= `JDR_RST_BYTE;
      link_mode <= `JDR_RST_BYTE;
      lane_inv <= `JDR_RST_BYTE;
      descr_ctl <= '0;
      rotated <= 1'b0;
      tripped <= 1'b0;
      locked <= 1'b0;
      win_limit <= 1'b0;
      state <= JDR_ST_IDLE;
      after_rot <= JDR_ST_IDLE;
      rot_cnt <= '0;
      reg_rdata <= `JDR_RST_BYTE;
      ref_cnt <= `JDR_LMFC_ZERO;
      lmfc_cnt <= '0;
      lmfc_edge <= '0;
    end else begin
      err_window <= next_err_window;
      snap_err <= next_snap_err;
      snap_flags <= next_snap_flags;
      sync_ctl <= next_sync_ctl;
      live_err <= next_live_err;
      win_flags <= next_win_flags;
      link_mode <= next_link_mode;
      lane_inv <= next_lane_inv;
      descr_ctl <= next_descr_ctl;
      rotated <= next_rotated;
      tripped <= next_tripped;
      locked <= next_locked;
      win_limit <= next_win_limit;
      state <= next_state;
      after_rot <= next_after_rot;
      rot_cnt <= next_rot_cnt;
      reg_rdata <= next_rdata;
      ref_cnt <= next_ref_cnt;
      lmfc_cnt <= next_lmfc_cnt;
      lmfc_edge <= next_lmfc_edge;
    end
  end

  // lane datapath: lanes 0-3 feed deframer 0, lanes 4-7 deframer 1
  logic [`JDR_LANES-1:0][`JDR_OCTETS-1:0][`JDR_OCT_W-1:0] lane_oct;
  logic [`JDR_LANES-1:0][`JDR_OCTETS-1:0] lane_k;
  logic [`JDR_LANES-1:0][`JDR_OCTETS-1:0] lane_err;
  logic [`JDR_LINKS-1:0] link_valid, next_link_valid;

  for (genvar ln = 0; ln < `JDR_LANES; ln++) begin : g_lane
    localparam int LINK = ln / `JDR_LANES_PER_LINK;
    logic [`JDR_SCR_LEN-1:0] hist, next_hist;
    logic [31:0] next_oct;
    logic [`JDR_OCTETS-1:0] next_k, next_err;

    always_comb begin
      logic [9:0] sym;
      logic [9:0] dec;
      logic [31:0] raw;
      logic [`JDR_SCR_LEN+31:0] ds;
      logic [`JDR_OCTETS-1:0] k;
      logic [`JDR_OCTETS-1:0] e;
      sym = '0;
      dec = '0;
      raw = '0;
      k = '0;
      e = '0;
      ds = '0;
      for (int o = 0; o < `JDR_OCTETS; o++) begin
        sym = lane_sym[ln][o] ^ {`JDR_SYM_W{lane_inv[ln]}}; // see [RQ1]
        dec = decode_symbol(sym); // see [RQ5]
        raw[o*`JDR_OCT_W +: `JDR_OCT_W] = dec[7:0];
        k[o] = dec[8];
        e[o] = dec[9];
      end
      ds = descramble_word(raw, hist);
      next_hist = hist;
      next_oct = lane_oct[ln];
      next_k = lane_k[ln];
      next_err = lane_err[ln];
      if (link_on[LINK] && lane_valid[LINK]) begin // see [RQ2] [RQ3]
        next_hist = ds[`JDR_SCR_LEN+31:32];
        next_oct = descr_on[LINK] ? ds[31:0] : raw; // see [RQ7]
        next_k = k;
        next_err = e;
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        hist <= '0;
        lane_oct[ln] <= '0;
        lane_k[ln] <= '0;
        lane_err[ln] <= '0;
      end else begin
        hist <= next_hist;
        lane_oct[ln] <= next_oct;
        lane_k[ln] <= next_k;
        lane_err[ln] <= next_err;
      end
    end
  end

  assign next_link_valid = link_on & lane_valid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_valid <= '0;
    end else begin
      link_valid <= next_link_valid;
    end
  end

  for (genvar lk = 0; lk < `JDR_LINKS; lk++) begin : g_link
    assign frame_out[lk] = {link_valid[lk],
                            lane_oct[lk*`JDR_LANES_PER_LINK +: `JDR_LANES_PER_LINK],
                            lane_k[lk*`JDR_LANES_PER_LINK +: `JDR_LANES_PER_LINK],
                            lane_err[lk*`JDR_LANES_PER_LINK +: `JDR_LANES_PER_LINK]};
  end

endmodule // jdr_rx_link

// ### test/jdr_rx_link_properties.sv
/*
  Concurrent checks on the register port, frame outputs and lmfc pulses.
  Assumes jdr_pkg is compiled first; bound into jdr_rx_link.
*/
`timescale 1ns/100ps
`include "jdr_defs.svh"
module jdr_rx_link_checker (
  input logic core_clk, // processing clock
  input logic rst, // synchronous reset
  input jdr_pkg::jdr_reg_req_type reg_req, // register request
  input logic [`JDR_DATA_W-1:0] reg_rdata, // read data
  input logic [`JDR_LINKS-1:0] lane_valid, // symbols valid per link
  input jdr_pkg::jdr_frame_type [`JDR_LINKS-1:0] frame_out, // frames per link
  input logic [`JDR_LINKS-1:0] lmfc_edge // lmfc pulses per pair
);
  import jdr_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (
    reg_req.rd && reg_req.addr == 12'h0FF |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_inv_readback: assert property (
    reg_req.wr && !reg_req.rd && reg_req.addr == `JDR_A_LANE_INV ##1 !reg_req.wr ##1
    reg_req.rd && reg_req.addr == `JDR_A_LANE_INV |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("mask not read back");
  a_clear_reads0: assert property (
    reg_req.rd && reg_req.addr == `JDR_A_SYNC_CTL |=> !reg_rdata[`JDR_B_CLR_STICKY])
    else $error("clear bit reads set");
  a_frame_taken: assert property (lane_valid[0] |=> frame_out[0].valid)
    else $error("link 0 frame missing");
  a_frame_quiet: assert property (
    !lane_valid[0] |=> !frame_out[0].valid && $stable(frame_out[0].data))
    else $error("link 0 stray frame");
  a_link1_quiet: assert property (
    !lane_valid[1] |=> !frame_out[1].valid && $stable(frame_out[1].data))
    else $error("link 1 stray frame");
  a_lmfc_gap: assert property (lmfc_edge[0] |=> !lmfc_edge[0] [*8])
    else $error("pair A pulses close");
  a_lmfc_recur: assert property (lmfc_edge[1] |-> ##[1:64] lmfc_edge[1])
    else $error("pair B stopped");
  c_link1: cover property (frame_out[1].valid);
  c_lmfc: cover property (lmfc_edge[0] && lmfc_edge[1]);
  c_readback: cover property (reg_req.wr ##2 reg_req.rd);
endmodule // jdr_rx_link_checker
bind jdr_rx_link jdr_rx_link_checker i_jdr_rx_link_checker (.core_clk(core_clk), .rst(rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .lane_valid(lane_valid),
  .frame_out(frame_out), .lmfc_edge(lmfc_edge));

// ### test/jdr_tx_model.sv
/*
  Behavioural transmitter: lane symbols per link and SYSREF pulses or steps.
  Assumes the bench calls its tasks just after a rising edge.
*/
`timescale 1ns/100ps
module jdr_tx_model (
  input logic core_clk, // processing clock
  output jdr_pkg::jdr_sym_bus_type lane_sym, // symbols to all lanes
  output logic [1:0] lane_valid, // per link valid
  output logic sysref // reference, active high
);
  import jdr_pkg::*;
  initial begin
    lane_sym = '1;
    lane_valid = 2'b00;
    sysref = 1'b0;
  end
  task automatic send(input logic [1:0] links, input logic [9:0] sym, input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1 lane_valid = links;
      lane_sym = {32{sym}};
    end
    @(posedge core_clk);
    #1 lane_valid = 2'b00;
    lane_sym = ~lane_sym; // idle lanes change
  endtask
  task automatic pulse(input int len); // short: pulse, long: step
    @(posedge core_clk);
    #1 sysref = 1'b1;
    repeat (len) @(posedge core_clk);
    #1 sysref = 1'b0;
  endtask
endmodule // jdr_tx_model

// ### test/tb.sv
/*
  Self-checking bench: lanes, links, registers and sync modes.
  Assumes package, block, model and checker compiled first.
*/
`timescale 1ns/100ps
module tb;
  import jdr_pkg::*;
  typedef struct {string n; logic [127:0] v; logic [127:0] m;} jdr_note_type;
  localparam logic [9:0] data_sym = 10'h319; // octet 0x23
  logic core_clk;
  logic rst;
  jdr_reg_req_type reg_req;
  logic [7:0] reg_rdata;
  jdr_sym_bus_type lane_sym;
  logic [1:0] lane_valid;
  logic subclass1;
  logic sysref;
  logic [1:0] dual_sync_sel;
  jdr_frame_type [1:0] frame_out;
  logic [1:0] lmfc_edge;
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'h000104C3;
  int mismatches = 0;
  int compares = 0;
  jdr_note_type rq[$], fq0[$], fq1[$];
  jdr_rx_link i_jdr_rx_link (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .lane_sym(lane_sym), .lane_valid(lane_valid),
    .subclass1(subclass1), .sysref(sysref), .dual_sync_sel(dual_sync_sel),
    .frame_out(frame_out), .lmfc_edge(lmfc_edge));
  jdr_tx_model i_jdr_tx_model (.core_clk(core_clk), .lane_sym(lane_sym),
    .lane_valid(lane_valid), .sysref(sysref));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic check(input string n, input logic [127:0] seen, input logic [127:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, want, seen);
    end
  endtask
  task automatic take(ref jdr_note_type q[$], input logic [127:0] seen);
    jdr_note_type e;
    if (q.size() == 0) begin
      check("unexpected output", 1, 0);
    end else begin
      e = q.pop_front();
      check(e.n, seen & e.m, e.v & e.m);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_req = '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    #1 reg_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m, string n);
    rq.push_back('{n, {120'h0, e}, {120'h0, m}});
    @(posedge core_clk);
    #1 reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    #1 reg_req.rd = 1'b0;
  endtask
  task automatic fexp(input bit l, input logic [3:0] inv, input logic [7:0] b, string n);
    jdr_note_type e;
    e.n = n;
    e.m = '1;
    for (int i = 0; i < 16; i++) e.v[i*8 +: 8] = inv[i/4] ? 8'hDC : b;
    if (l) fq1.push_back(e);
    else fq0.push_back(e);
  endtask
  task automatic ref_pulse(input int len);
    seed = xs(seed);
    for (int i = 0; i < 40 && lmfc_edge[0] !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    repeat (4 + seed[3:0]) @(posedge core_clk);
    i_jdr_tx_model.pulse(len);
    repeat (12) @(posedge core_clk);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) rd_seen <= reg_req.rd;
  always @(negedge core_clk) if (!rst) begin
    if (rd_seen) take(rq, {120'h0, reg_rdata});
    if (frame_out[0].valid !== 1'b0) take(fq0, frame_out[0].data);
    if (frame_out[1].valid !== 1'b0) take(fq1, frame_out[1].data);
  end
  initial begin
    #100000;
    mismatches++;
    $display("watchdog expired");
    print_verdict;
  end
  initial begin
    rst = 1'b1;
    reg_req = '0;
    subclass1 = 1'b1;
    dual_sync_sel = 2'b11;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    seed = xs(seed);
    rd(12'h0FF, 8'h00, 8'hFF, "unmapped");
    wr(12'h334, seed[7:0]);
    rd(12'h334, seed[7:0], 8'hFF, "invert mask");
    fexp(1'b0, seed[3:0], 8'h23, "inverted lanes");
    i_jdr_tx_model.send(2'b11, data_sym, 1);
    wr(12'h334, 8'h00);
    repeat (2) fexp(1'b0, 4'h0, 8'h23, "plain");
    i_jdr_tx_model.send(2'b01, data_sym, 2);
    wr(12'h453, 8'h80);
    repeat (2) fexp(1'b0, 4'h0, 8'hE9, "descrambled");
    i_jdr_tx_model.send(2'b01, data_sym, 2);
    wr(12'h453, 8'h00);
    $display("lane tests done");
    wr(12'h300, 8'h08);
    fexp(1'b0, 4'h0, 8'h23, "link 0");
    fexp(1'b1, 4'h0, 8'h23, "link 1");
    i_jdr_tx_model.send(2'b11, data_sym, 1);
    wr(12'h300, 8'h0C);
    wr(12'h453, 8'h80);
    wr(12'h300, 8'h08);
    rd(12'h453, 8'h00, 8'hFF, "bank 0");
    fexp(1'b0, 4'h0, 8'h23, "link 0 plain");
    fexp(1'b1, 4'h0, 8'hE9, "link 1 descrambled");
    i_jdr_tx_model.send(2'b11, data_sym, 1);
    wr(12'h300, 8'h00);
    $display("link tests done");
    wr(12'h03A, 8'hC1);
    ref_pulse(1);
    rd(12'h03B, 8'h05, 8'h85, "one-shot status");
    rd(12'h03A, 8'h81, 8'hFF, "arm cleared");
    rd(12'h03C, 8'h00, 8'hFF, "live error");
    wr(12'h03A, 8'hA1);
    ref_pulse(1);
    rd(12'h03B, 8'h00, 8'h05, "unarmed edge");
    wr(12'h03A, 8'hC2);
    ref_pulse(60);
    rd(12'h03B, 8'h01, 8'h01, "continuous");
    rd(12'h03A, 8'h82, 8'hFF, "edge indicator");
    wr(12'h03A, 8'h00);
    wr(12'h03A, 8'hE9);
    ref_pulse(1);
    wr(12'h03A, 8'hA9);
    ref_pulse(1);
    rd(12'h03B, 8'h01, 8'h05, "monitor");
    rd(12'h03D, seed[3:0] < 9 ? 8'h40 : 8'h80, 8'hFF, "side");
    wr(12'h03A, 8'h00);
    subclass1 = 1'b0;
    wr(12'h03A, 8'hE1);
    repeat (40) @(posedge core_clk);
    rd(12'h03B, 8'h01, 8'h01, "internal edge");
    wr(12'h034, 8'h03);
    rd(12'h034, 8'h03, 8'hFF, "window code");
    $display("sync tests done");
    repeat (4) @(posedge core_clk);
    check("pending", rq.size() + fq0.size() + fq1.size(), 0);
    print_verdict;
  end
endmodule // tb
